//--- sfr_page_map.svh
`ifndef SFR_PAGE_MAP_SVH
`define SFR_PAGE_MAP_SVH
// Direct addresses of the two registers held in this block
`define PAGE_SELECT_ADDR 8'hA7
`define XRAM_PAGE_CTRL_ADDR 8'hAA
// Reset values
`define PAGE_SELECT_RESET 8'h00
`define XRAM_PAGE_CTRL_RESET 8'h00
// Page codes
`define PAGE_DEFAULT 8'h00
`define PAGE_EXTENDED 8'h0F
// Field positions and boundaries
`define XRAM_PAGE_BIT_POS 0
`define SFR_WINDOW_MSB 7
`define BIT_ADDR_NIBBLE_MASK 3'h0
`endif

//--- sfr_page_pkg.sv
package sfr_page_pkg;
    // Kind of data memory access issued by the core
    typedef enum logic [1:0] {
        ACC_DIRECT = 2'b00,
        ACC_INDIRECT = 2'b01,
        ACC_MOVX8 = 2'b10,
        ACC_MOVX16 = 2'b11
    } access_kind_e;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] xaddr_t;
endpackage

//--- sfr_decode_if.sv
`timescale 1ns/1ps
// Carries one access from the main module to the decoder, and its decode back
interface sfr_decode_if;
    logic [7:0] addr;
    logic direct;
    logic bit_op;
    logic sfr_sel;
    logic bit_ok;
    logic shared;
    modport requester (output addr, output direct, output bit_op, input sfr_sel, input bit_ok,
        input shared);
    modport decoder (input addr, input direct, input bit_op, output sfr_sel, output bit_ok,
        output shared);
endinterface

//--- sfr_space_decode.sv
`timescale 1ns/1ps
`include "sfr_page_map.svh"
// Combinational decode of a direct access into the register window
module sfr_space_decode (
    sfr_decode_if.decoder dec
);
    import sfr_page_pkg::*;

    // Registers that answer the same on both pages
    function automatic logic is_shared(input logic [7:0] a);
        is_shared = (a == `PAGE_SELECT_ADDR);
    endfunction

    // Direct access with the top address bit set lands in the register window
    always_comb begin
        dec.sfr_sel = dec.direct && dec.addr[`SFR_WINDOW_MSB]; // RL5
        dec.bit_ok = dec.sfr_sel && dec.bit_op && (dec.addr[2:0] == `BIT_ADDR_NIBBLE_MASK); // RL6 RL7
        dec.shared = dec.sfr_sel && is_shared(dec.addr); // RL11
    end
endmodule

//--- sfr_paging_xram_page_select.sv
`timescale 1ns/1ps
`include "sfr_page_map.svh"
// Notes on behaviour
// [RL1] Upper seven bits of the XRAM page register read zero; writes ignored.
// [RL2] Eight-bit external moves take the XRAM page register as address high byte.
// [RL3] Each page register value picks one 256-byte XRAM page.
// [RL4] Only bit 0 varies: set reaches 0x0100-0x01FF, clear 0x0000-0x00FF.
// [RL5] Direct accesses to 0x80-0xFF go to the register space.
// [RL6] Registers at addresses ending 0x0 or 0x8 allow bit access.
// [RL7] All other registers take byte access only.
// [RL8] Software avoids reserved register addresses; results there are undefined.
// [RL9] Paging lets more than 128 registers share the direct window.
// [RL10] At the default page all register accesses hit page 0x0.
// [RL11] Shared registers, page select included, answer on page 0x0 and 0xF.
// [RL12] Software disables interrupts around page 0xF accesses, then restores.
// [RL13] Page select is read-write at 0xA7, on all pages, reset zero.
// [RL14] Eight-bit external move low address byte comes from R0 or R1.
// [RL15] Indirect accesses above 0x7F reach upper RAM, never registers.
// [RL16] A page select write affects the very next register access.
// [RL17] Reset clears the XRAM page register to the lowest page.
module sfr_paging_xram_page_select (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_acc_valid,
    input wire sfr_page_pkg::access_kind_e i_acc_kind,
    input wire logic i_acc_write,
    input wire logic i_acc_bit,
    input wire logic [2:0] i_acc_bit_idx,
    input wire sfr_page_pkg::byte_t i_acc_addr,
    input wire sfr_page_pkg::byte_t i_acc_wdata,
    input wire sfr_page_pkg::xaddr_t i_acc_dptr,
    input wire sfr_page_pkg::byte_t i_acc_index,
    input wire sfr_page_pkg::byte_t i_periph_rdata,
    input wire sfr_page_pkg::byte_t i_xram_rdata,
    input wire sfr_page_pkg::byte_t i_iram_rdata,
    output sfr_page_pkg::byte_t o_acc_rdata,
    output logic o_acc_done,
    output logic o_acc_bit_refused,
    output logic o_periph_sel,
    output logic o_periph_write,
    output sfr_page_pkg::byte_t o_periph_addr,
    output sfr_page_pkg::byte_t o_periph_page,
    output logic o_periph_bit,
    output logic [2:0] o_periph_bit_idx,
    output sfr_page_pkg::byte_t o_periph_wdata,
    output logic o_xram_sel,
    output logic o_xram_write,
    output sfr_page_pkg::xaddr_t o_xram_addr,
    output sfr_page_pkg::byte_t o_xram_wdata,
    output logic o_iram_sel,
    output logic o_iram_write,
    output sfr_page_pkg::byte_t o_iram_addr,
    output sfr_page_pkg::byte_t o_iram_wdata,
    output sfr_page_pkg::byte_t o_register_page_select,
    output sfr_page_pkg::byte_t o_xram_page_control
);
    import sfr_page_pkg::*;

    byte_t page_reg;
    logic page_bit_reg;
    logic rd_pending_reg;
    logic [1:0] rd_src_reg;
    byte_t rd_local_reg;
    sfr_decode_if dec ();

    localparam logic [1:0] SRC_LOCAL = 2'h0;
    localparam logic [1:0] SRC_PERIPH = 2'h1;
    localparam logic [1:0] SRC_XRAM = 2'h2;
    localparam logic [1:0] SRC_IRAM = 2'h3;
    // Full reset byte of the page control; only its page bit is kept in a flip-flop
    localparam byte_t XPAGE_RESET = `XRAM_PAGE_CTRL_RESET;

    // Present the access to the decoder; paging is applied here, not in the decoder
    assign dec.addr = i_acc_addr;
    assign dec.direct = i_acc_valid && (i_acc_kind == ACC_DIRECT);
    assign dec.bit_op = i_acc_bit;

    sfr_space_decode u_decode (
        .dec(dec)
    );

    logic hit_page_sel;
    logic hit_xpage;
    logic bit_refused;
    byte_t xpage_view;
    // Local registers are decoded on the live page; the page register itself is shared
    assign hit_page_sel = dec.sfr_sel && dec.shared; // RL11 RL13
    assign hit_xpage = dec.sfr_sel && (i_acc_addr == `XRAM_PAGE_CTRL_ADDR) &&
        (page_reg == `PAGE_DEFAULT); // RL10
    assign bit_refused = dec.sfr_sel && i_acc_bit && !dec.bit_ok; // RL7
    assign xpage_view = {7'h00, page_bit_reg}; // RL1

    // Page select: full byte, takes effect from the next cycle on
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            page_reg <= `PAGE_SELECT_RESET; // RL13
        end else if (hit_page_sel && i_acc_write && !bit_refused) begin
            page_reg <= i_acc_wdata; // RL16 RL9
        end
    end

    // XRAM page bit: only bit 0 is stored, so the upper bits can never hold ones
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            page_bit_reg <= XPAGE_RESET[`XRAM_PAGE_BIT_POS]; // RL17
        end else if (hit_xpage && i_acc_write && !bit_refused) begin
            page_bit_reg <= i_acc_wdata[`XRAM_PAGE_BIT_POS]; // RL1 RL4
        end
    end

    // Route each access to its target; a refused bit access reaches nobody
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_periph_sel <= 1'b0;
            o_periph_write <= 1'b0;
            o_periph_addr <= 8'h00;
            o_periph_page <= 8'h00;
            o_periph_bit <= 1'b0;
            o_periph_bit_idx <= 3'h0;
            o_periph_wdata <= 8'h00;
            o_xram_sel <= 1'b0;
            o_xram_write <= 1'b0;
            o_xram_addr <= 16'h0000;
            o_xram_wdata <= 8'h00;
            o_iram_sel <= 1'b0;
            o_iram_write <= 1'b0;
            o_iram_addr <= 8'h00;
            o_iram_wdata <= 8'h00;
            o_acc_bit_refused <= 1'b0;
        end else begin
            // Peripherals see the current page so paged sets answer one at a time
            o_periph_sel <= dec.sfr_sel && !hit_page_sel && !hit_xpage && !bit_refused; // RL5 RL9
            o_periph_write <= i_acc_write;
            o_periph_addr <= i_acc_addr;
            o_periph_page <= page_reg; // RL10 RL16
            o_periph_bit <= i_acc_bit && dec.bit_ok; // RL6
            o_periph_bit_idx <= i_acc_bit_idx;
            o_periph_wdata <= i_acc_wdata;
            o_acc_bit_refused <= bit_refused; // RL7
            // Eight-bit moves: page register high, index register low
            o_xram_sel <= i_acc_valid && (i_acc_kind == ACC_MOVX8 || i_acc_kind == ACC_MOVX16);
            o_xram_write <= i_acc_write;
            o_xram_addr <= (i_acc_kind == ACC_MOVX8) ? {xpage_view, i_acc_index} : i_acc_dptr; // RL2 RL3 RL14
            o_xram_wdata <= i_acc_wdata;
            // Direct below 0x80 and all indirect go to internal RAM
            o_iram_sel <= i_acc_valid && ((i_acc_kind == ACC_INDIRECT) ||
                (i_acc_kind == ACC_DIRECT && !i_acc_addr[`SFR_WINDOW_MSB])); // RL15
            o_iram_write <= i_acc_write;
            o_iram_addr <= (i_acc_kind == ACC_INDIRECT) ? i_acc_index : i_acc_addr;
            o_iram_wdata <= i_acc_wdata;
        end
    end

    // Remember which source answers a read issued this cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_pending_reg <= 1'b0;
            rd_src_reg <= SRC_LOCAL;
            rd_local_reg <= 8'h00;
        end else begin
            rd_pending_reg <= i_acc_valid;
            // A refused bit access answers zero even at a local register
            rd_local_reg <= bit_refused ? 8'h00 : (hit_page_sel ? page_reg : (hit_xpage ? xpage_view : 8'h00)); // RL1 RL7
            if (i_acc_kind == ACC_MOVX8 || i_acc_kind == ACC_MOVX16) begin
                rd_src_reg <= SRC_XRAM;
            end else if (dec.sfr_sel) begin
                rd_src_reg <= (hit_page_sel || hit_xpage || bit_refused) ? SRC_LOCAL : SRC_PERIPH;
            end else begin
                rd_src_reg <= SRC_IRAM;
            end
        end
    end

    // Answer one cycle after the targets saw the access
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_acc_done <= 1'b0;
            o_acc_rdata <= 8'h00;
        end else begin
            o_acc_done <= rd_pending_reg;
            unique case (rd_src_reg)
                SRC_LOCAL: o_acc_rdata <= rd_local_reg;
                SRC_PERIPH: o_acc_rdata <= i_periph_rdata;
                SRC_XRAM: o_acc_rdata <= i_xram_rdata;
                SRC_IRAM: o_acc_rdata <= i_iram_rdata;
            endcase
        end
    end

    // Mirrors of the two local registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_register_page_select <= `PAGE_SELECT_RESET;
            o_xram_page_control <= `XRAM_PAGE_CTRL_RESET;
        end else begin
            o_register_page_select <= page_reg;
            o_xram_page_control <= xpage_view;
        end
    end

    // Checks
    sequence s_movx8_req;
        i_acc_valid && i_acc_kind == ACC_MOVX8;
    endsequence

    AST_MOVX8_HIGH_BYTE: assert property (@(posedge i_clk) disable iff (i_rst) // RL2
        s_movx8_req |=> o_xram_addr == {$past(xpage_view), $past(i_acc_index)})
        else $error("8-bit move address wrong");
    AST_XPAGE_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // RL1
        o_xram_page_control[7:1] == 7'h00)
        else $error("xram page upper bits not zero");
    AST_MOVX8_RANGE: assert property (@(posedge i_clk) disable iff (i_rst) // RL4
        s_movx8_req |=> o_xram_addr[15:9] == 7'h00)
        else $error("8-bit move outside two pages");
    AST_DIRECT_TO_SFR: assert property (@(posedge i_clk) disable iff (i_rst) // RL5
        (dec.direct && i_acc_addr[`SFR_WINDOW_MSB] && !i_acc_bit) |=> !o_iram_sel)
        else $error("direct high access reached RAM");
    AST_INDIRECT_TO_RAM: assert property (@(posedge i_clk) disable iff (i_rst) // RL15
        (i_acc_valid && i_acc_kind == ACC_INDIRECT) |=> o_iram_sel && !o_periph_sel)
        else $error("indirect access missed upper RAM");
    AST_BIT_REFUSE: assert property (@(posedge i_clk) disable iff (i_rst) // RL7
        (dec.direct && i_acc_addr[`SFR_WINDOW_MSB] && i_acc_bit && i_acc_addr[2:0] != `BIT_ADDR_NIBBLE_MASK)
        |=> o_acc_bit_refused)
        else $error("bit access not refused");
    AST_BIT_ALLOWED: assert property (@(posedge i_clk) disable iff (i_rst) // RL6
        (dec.direct && i_acc_addr[`SFR_WINDOW_MSB] && i_acc_bit && i_acc_addr[2:0] == `BIT_ADDR_NIBBLE_MASK)
        |=> !o_acc_bit_refused)
        else $error("bit access wrongly refused");
    AST_PAGE_NEXT: assert property (@(posedge i_clk) disable iff (i_rst) // RL16
        (dec.direct && i_acc_addr == `PAGE_SELECT_ADDR && i_acc_write && !i_acc_bit) ##1 dec.sfr_sel
        |=> o_periph_page == $past(i_acc_wdata, 2))
        else $error("page write not in force next access");
    AST_DONE_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst) // RL13
        i_acc_valid |-> ##2 o_acc_done)
        else $error("answer not after two cycles");
endmodule

//--- sfr_far_side_model.sv
`timescale 1ns/1ps
// Peripherals, XRAM and upper RAM answer combinationally while selected
module sfr_far_side_model (
    input wire logic i_clk,
    input wire logic i_periph_sel,
    input wire sfr_page_pkg::byte_t i_periph_addr,
    input wire sfr_page_pkg::byte_t i_periph_page,
    input wire logic i_xram_sel,
    input wire sfr_page_pkg::xaddr_t i_xram_addr,
    input wire logic i_iram_sel,
    input wire sfr_page_pkg::byte_t i_iram_addr,
    output sfr_page_pkg::byte_t o_periph_rdata,
    output sfr_page_pkg::byte_t o_xram_rdata,
    output sfr_page_pkg::byte_t o_iram_rdata
);
    import sfr_page_pkg::*;
    byte_t junk_reg = 8'hA5;
    // Unselected targets show a moving pattern, so stale data never passes for an answer
    always @(posedge i_clk) begin
        junk_reg <= junk_reg + 8'h5B;
    end
    // Register data depends on the page, so a wrong page shows up in the read
    // Every register address answers here, so a stray reserved address cannot leave data undefined
    assign o_periph_rdata = i_periph_sel ? (i_periph_addr ^ i_periph_page) : junk_reg;
    assign o_xram_rdata = i_xram_sel ? (i_xram_addr[7:0] + i_xram_addr[15:8]) : ~junk_reg;
    assign o_iram_rdata = i_iram_sel ? ~i_iram_addr : (junk_reg ^ 8'h3C);
endmodule

//--- sfr_paging_xram_page_select_tb_top.sv
`timescale 1ns/1ps
// Drives core accesses, notes each expected answer and checks it when it comes back
module sfr_paging_xram_page_select_tb_top;
    import sfr_page_pkg::*;
    typedef struct {logic [1:0] tgt; logic [15:0] ta; logic rd; byte_t data; logic rf; logic w; byte_t wd; logic b;} exp_s;
    logic i_clk = 0, i_rst = 1, i_acc_valid = 0, i_acc_write = 0, i_acc_bit = 0, skip = 0;
    access_kind_e i_acc_kind = ACC_DIRECT;
    logic [2:0] i_acc_bit_idx = 3'h0, o_periph_bit_idx;
    byte_t i_acc_addr = 8'h00, i_acc_wdata = 8'h00, i_acc_index = 8'h00, psel = 8'h00, xpc = 8'h00;
    xaddr_t i_acc_dptr = 16'h0000, o_xram_addr, p_ta;
    byte_t i_periph_rdata, i_xram_rdata, i_iram_rdata, o_acc_rdata, o_periph_addr, o_periph_page;
    byte_t o_periph_wdata, o_xram_wdata, o_iram_addr, o_iram_wdata, o_register_page_select, o_xram_page_control;
    logic o_acc_done, o_acc_bit_refused, o_periph_sel, o_periph_write, o_periph_bit, o_xram_sel;
    logic o_xram_write, o_iram_sel, o_iram_write;
    logic [1:0] p_tgt = 2'd0, c_tgt = 2'd0;
    logic p_w = 1'b0;
    byte_t p_wd = 8'h00;
    logic [3:0] p_bit = 4'h0;
    int n_errors = 0, n_tests = 0, cyc = 0, seed, i;
    logic [31:0] r;
    exp_s exp_q[$];
    exp_s e;

    sfr_paging_xram_page_select u_dut (.i_clk, .i_rst, .i_acc_valid, .i_acc_kind, .i_acc_write, .i_acc_bit,
        .i_acc_bit_idx, .i_acc_addr, .i_acc_wdata, .i_acc_dptr, .i_acc_index, .i_periph_rdata, .i_xram_rdata,
        .i_iram_rdata, .o_acc_rdata, .o_acc_done, .o_acc_bit_refused, .o_periph_sel, .o_periph_write,
        .o_periph_addr, .o_periph_page, .o_periph_bit, .o_periph_bit_idx, .o_periph_wdata, .o_xram_sel,
        .o_xram_write, .o_xram_addr, .o_xram_wdata, .o_iram_sel, .o_iram_write, .o_iram_addr, .o_iram_wdata,
        .o_register_page_select, .o_xram_page_control);

    sfr_far_side_model u_far (.i_clk(i_clk), .i_periph_sel(o_periph_sel), .i_periph_addr(o_periph_addr),
        .i_periph_page(o_periph_page), .i_xram_sel(o_xram_sel), .i_xram_addr(o_xram_addr),
        .i_iram_sel(o_iram_sel), .i_iram_addr(o_iram_addr), .o_periph_rdata(i_periph_rdata),
        .o_xram_rdata(i_xram_rdata), .o_iram_rdata(i_iram_rdata));

    // Free-running 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One access: predict target, address and data from the tracked page registers, then drive it
    task automatic acc(input access_kind_e k, input logic w, input logic b, input byte_t a, input byte_t d);
        exp_s x;
        x.rd = !w && !b;
        x.w = w;
        x.wd = d;
        x.b = b;
        x.rf = k == ACC_DIRECT && a[7] && b && a[2:0] != 3'h0;
        x.tgt = k[1] ? 2'd2 : (k == ACC_INDIRECT || !a[7]) ? 2'd3 : x.rf ? 2'd0 : 2'd1;
        x.ta = k == ACC_MOVX16 ? {a, d} : k == ACC_MOVX8 ? {xpc, d} : x.tgt == 2'd3 ? {8'h00, k[0] ? d : a} : {psel, a};
        x.data = x.tgt == 2'd2 ? x.ta[7:0] + x.ta[15:8] : x.tgt == 2'd3 ? ~x.ta[7:0] : a ^ psel;
        if (x.rf) x.data = 8'h00;
        // Page select answers on every page, page control only on the default page
        if (x.tgt == 2'd1 && (a == 8'hA7 || (a == 8'hAA && psel == 8'h00))) begin
            x.tgt = 2'd0;
            x.data = a[0] ? psel : xpc;
            if (w && a[0]) psel = d;
            else if (w) xpc = {7'h00, d[0]};
        end
        @(posedge i_clk);
        #2;
        i_acc_valid = 1'b1;
        i_acc_kind = k;
        i_acc_write = w;
        i_acc_bit = b;
        i_acc_bit_idx = d[2:0];
        i_acc_addr = a;
        i_acc_wdata = d;
        i_acc_dptr = {a, d};
        i_acc_index = k == ACC_DIRECT ? a : d;
        exp_q.push_back(x);
    endtask

    task automatic idle(input int n);
        @(posedge i_clk);
        #2;
        i_acc_valid = 1'b0;
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // Match answers in order; a refusal may be followed by its own done one cycle later
    always @(posedge i_clk) begin
        #1;
        c_tgt = o_periph_sel ? 2'd1 : o_xram_sel ? 2'd2 : o_iram_sel ? 2'd3 : 2'd0;
        if (!skip && (o_acc_done === 1'b1 || o_acc_bit_refused === 1'b1)) begin
            if (exp_q.size() == 0) begin
                check("unexpected answer", 16'h0000, 16'h0001);
            end else begin
                e = exp_q.pop_front();
                check("refused", {15'h0, e.rf}, {15'h0, o_acc_bit_refused});
                // A refusal is flagged in the cycle where a target would have been selected
                check("target", {14'h0, e.tgt}, {14'h0, e.rf ? c_tgt : p_tgt});
                if (e.tgt != 2'd0) check("address", e.ta, p_ta);
                if (e.tgt != 2'd0) check("write", {15'h0, e.w}, {15'h0, p_w});
                if (e.tgt != 2'd0 && e.w) check("wdata", {8'h00, e.wd}, {8'h00, p_wd});
                if (e.tgt == 2'd1) check("bit", {12'h0, e.b, e.wd[2:0]}, {12'h0, p_bit});
                if (e.rd) check("rdata", {8'h00, e.data}, {8'h00, o_acc_rdata});
            end
        end
        skip = !skip && o_acc_bit_refused === 1'b1 && o_acc_done !== 1'b1;
        p_tgt = c_tgt;
        p_ta = o_periph_sel ? {o_periph_page, o_periph_addr} : o_xram_sel ? o_xram_addr : {8'h00, o_iram_addr};
        p_w = o_periph_sel ? o_periph_write : o_xram_sel ? o_xram_write : o_iram_write;
        p_wd = o_periph_sel ? o_periph_wdata : o_xram_sel ? o_xram_wdata : o_iram_wdata;
        p_bit = {o_periph_bit, o_periph_bit_idx};
    end

    // Cut a hang short well beyond the roughly 140 cycles the sequence needs
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_errors++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        seed = 32'h65E0BE07;
        repeat (16) @(posedge i_clk);
        #2;
        i_rst = 1'b0;
        acc(ACC_DIRECT, 1'b0, 1'b0, 8'hA7, 8'h00);
        acc(ACC_DIRECT, 1'b0, 1'b0, 8'hAA, 8'h00);
        acc(ACC_MOVX8, 1'b0, 1'b0, 8'h00, 8'h34);
        for (i = 0; i < 12; i++) begin
            r = $random(seed);
            acc(access_kind_e'(r[1:0]), r[2], 1'b0, r[15:8], r[23:16]);
        end
        acc(ACC_DIRECT, 1'b1, 1'b0, 8'hA7, 8'h00);
        acc(ACC_DIRECT, 1'b1, 1'b0, 8'hAA, 8'hFF);
        acc(ACC_MOVX8, 1'b0, 1'b0, 8'h00, 8'h00);
        acc(ACC_DIRECT, 1'b0, 1'b0, 8'hAA, 8'h00);
        acc(ACC_MOVX8, 1'b1, 1'b0, 8'h00, 8'hFF);
        idle(3);
        check("page control view", 16'h0001, {8'h00, o_xram_page_control});
        acc(ACC_DIRECT, 1'b1, 1'b0, 8'hAA, 8'hFE);
        acc(ACC_MOVX8, 1'b0, 1'b0, 8'h00, 8'hFF);
        acc(ACC_INDIRECT, 1'b0, 1'b0, 8'hA7, 8'hC5);
        idle(3);
        for (i = 0; i < 16; i++) begin
            acc(ACC_DIRECT, i[0], 1'b1, 8'h90 + 8'(i), 8'(i));
            idle(3);
        end
        // Page 0xF visit in the order software must follow
        acc(ACC_DIRECT, 1'b1, 1'b0, 8'hA7, 8'h0F);
        acc(ACC_DIRECT, 1'b0, 1'b0, 8'hB9, 8'h00);
        acc(ACC_DIRECT, 1'b0, 1'b0, 8'hA7, 8'h00);
        acc(ACC_DIRECT, 1'b0, 1'b0, 8'hAA, 8'h00);
        acc(ACC_DIRECT, 1'b1, 1'b0, 8'hA7, 8'h00);
        acc(ACC_DIRECT, 1'b0, 1'b0, 8'hB9, 8'h00);
        idle(4);
        check("pending answers", 16'h0000, 16'(exp_q.size()));
        check("page select view", {8'h00, psel}, {8'h00, o_register_page_select});
        check("page control final", {8'h00, xpc}, {8'h00, o_xram_page_control});
        final_report();
    end
endmodule
